/* File: design/baud_timer.sv */
module baud_timer (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic timer_enable_in,
	input wire logic [uart_pkg::BAUD_W-1:0] reload_in,
	input wire logic [uart_pkg::SEL_W-1:0] clock_select_in,
	input wire logic ext_osc_tick_in,
	input wire logic ext_count_input_in,
	input wire logic rx_force_reload_in,
	output logic tx_ovf_out,
	output logic rx_ovf_out
);
	import uart_pkg::*;
	typedef struct packed {
		logic [5:0] pre;
		logic [2:0] osc;
		logic ext_prev;
		logic [BAUD_W-1:0] tx_cnt;
		logic [BAUD_W-1:0] rx_cnt;
		logic tx_ovf;
		logic rx_ovf;
	} baud_state_t;
	baud_state_t st_ff;
	baud_state_t nxt_st;
	logic tick;
	function automatic logic src_tick(input logic [SEL_W-1:0] sel, input logic [5:0] pre,
			input logic osc_wrap, input logic ext_fall);
		case (sel)
			SRC_SYS: src_tick = 1'b1;
			SRC_DIV4: src_tick = pre[1:0] == DIV4_LAST;
			SRC_DIV12: src_tick = (pre % DIV12_MOD) == DIV12_LAST;
			SRC_DIV48: src_tick = pre == PRESCALE_LAST;
			SRC_EXT_OSC8: src_tick = osc_wrap;
			SRC_EXT_PIN: src_tick = ext_fall;
			default: src_tick = 1'b0;
		endcase
	endfunction
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tx_ovf = 1'b0;
		nxt_st.rx_ovf = 1'b0;
		nxt_st.pre = (st_ff.pre == PRESCALE_LAST) ? '0 : 6'(st_ff.pre + 1'b1);
		if (ext_osc_tick_in) begin
			nxt_st.osc = 3'(st_ff.osc + 1'b1);
		end
		nxt_st.ext_prev = ext_count_input_in;
		tick = timer_enable_in && src_tick(clock_select_in, st_ff.pre,
			ext_osc_tick_in && st_ff.osc == EXT_OSC_LAST, st_ff.ext_prev && !ext_count_input_in);
		if (tick) begin
			// overflow every 256 minus reload ticks
			if (st_ff.tx_cnt == BAUD_CNT_MAX) begin
				nxt_st.tx_cnt = reload_in;
				nxt_st.tx_ovf = 1'b1;
			end else begin
				nxt_st.tx_cnt = BAUD_W'(st_ff.tx_cnt + 1'b1);
			end
			if (st_ff.rx_cnt == BAUD_CNT_MAX) begin
				nxt_st.rx_cnt = reload_in;
				nxt_st.rx_ovf = 1'b1;
			end else begin
				nxt_st.rx_cnt = BAUD_W'(st_ff.rx_cnt + 1'b1);
			end
		end
		// start edge realigns the receive copy only
		if (timer_enable_in && rx_force_reload_in) begin
			nxt_st.rx_cnt = reload_in;
			nxt_st.rx_ovf = 1'b0;
		end
		if (!resetn_in) begin
			nxt_st = '0;
			nxt_st.tx_cnt = BAUD_CNT_RESET;
			nxt_st.rx_cnt = BAUD_CNT_RESET;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		st_ff <= nxt_st;
	end
	assign tx_ovf_out = st_ff.tx_ovf;
	assign rx_ovf_out = st_ff.rx_ovf;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	a_rx_forced_reload: assert property (
		(rx_force_reload_in && timer_enable_in) |=> st_ff.rx_cnt == $past(reload_in) && !st_ff.rx_ovf)
		else $error("receive copy not reloaded on start");
	a_tx_overflow_reload: assert property (
		st_ff.tx_ovf |-> st_ff.tx_cnt == $past(reload_in) && $past(st_ff.tx_cnt) == BAUD_CNT_MAX)
		else $error("transmit counter overflow did not reload");
endmodule

/* File: design/byte_fifo.sv */
module byte_fifo #(
	parameter int WIDTH = uart_pkg::DATA_W,
	parameter int DEPTH = uart_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	import uart_pkg::*;
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
		logic in_ready;
	} fifo_state_t;
	fifo_state_t st_ff;
	fifo_state_t nxt_st;
	logic push;
	logic pop;
	always_comb begin
		nxt_st = st_ff;
		push = in_valid_in && st_ff.in_ready;
		pop = out_valid_out && out_ready_in;
		if (push) begin
			nxt_st.mem[st_ff.wr] = in_data_in;
			nxt_st.wr = AW'(st_ff.wr + 1'b1);
		end
		if (pop) begin
			nxt_st.rd = AW'(st_ff.rd + 1'b1);
		end
		nxt_st.count = (AW+1)'(st_ff.count + push - pop);
		// ready is registered so the source sees back-pressure from a flop
		nxt_st.in_ready = nxt_st.count != (AW+1)'(DEPTH);
		if (!resetn_in) begin
			nxt_st = '0;
			nxt_st.in_ready = 1'b1;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		st_ff <= nxt_st;
	end
	assign in_ready_out = st_ff.in_ready;
	assign out_valid_out = st_ff.count != '0;
	assign out_data_out = st_ff.mem[st_ff.rd];
endmodule

/* File: design/serial_port.sv */
module serial_port (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic tx_write_in,
	input wire logic [uart_pkg::DATA_W-1:0] tx_write_data_in,
	output logic tx_ready_out,
	output logic [uart_pkg::DATA_W-1:0] rx_data_out,
	input wire logic frame_length_select_in,
	input wire logic address_filter_enable_in,
	input wire logic rx_enable_in,
	input wire logic tx_extra_bit_in,
	input wire logic serial_irq_enable_in,
	input wire logic tx_done_clr_in,
	input wire logic rx_done_clr_in,
	output logic tx_done_flag_out,
	output logic rx_done_flag_out,
	output logic rx_extra_bit_out,
	output logic serial_irq_out,
	input wire logic timer_enable_in,
	input wire logic [uart_pkg::BAUD_W-1:0] baud_reload_value_in,
	input wire logic [uart_pkg::SEL_W-1:0] baud_clock_select_in,
	input wire logic ext_osc_tick_in,
	input wire logic ext_count_input_in,
	input wire logic serial_in_pin_in,
	output logic serial_out_pin_out
);
	import uart_pkg::*;

	typedef struct packed {
		tx_state_t tx_state;
		logic [8:0] tx_shift;
		logic [3:0] tx_bits;
		logic tx_nine;
		logic tx_half;
		logic serial_out;
		logic tx_done;
		rx_state_t rx_state;
		logic [8:0] rx_shift;
		logic [3:0] rx_bits;
		logic rx_nine;
		logic rx_half;
		logic rx_prev;
		logic [DATA_W-1:0] rx_buf;
		logic rx_extra;
		logic rx_done;
		logic irq;
	} port_state_t;

	port_state_t st_ff;
	port_state_t nxt_st;
	logic tx_ovf;
	logic rx_ovf;
	logic rx_force;
	logic fifo_valid;
	logic fifo_ready;
	logic [DATA_W-1:0] fifo_data;
	logic tx_tick;
	logic rx_sample;
	logic rx_ninth;
	logic rx_accept;

	// writes land in the holding fifo; nothing reads the transmit side back
	byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) tx_hold (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(tx_write_in),
		.in_data_in(tx_write_data_in),
		.in_ready_out(tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(fifo_ready)
	);

	baud_timer baud (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.timer_enable_in(timer_enable_in),
		.reload_in(baud_reload_value_in),
		.clock_select_in(baud_clock_select_in),
		.ext_osc_tick_in(ext_osc_tick_in),
		.ext_count_input_in(ext_count_input_in),
		.rx_force_reload_in(rx_force),
		.tx_ovf_out(tx_ovf),
		.rx_ovf_out(rx_ovf)
	);

	// falling edge on an idle, enabled line is a start
	assign rx_force = st_ff.rx_state == RX_IDLE && rx_enable_in && st_ff.rx_prev && !serial_in_pin_in;
	assign fifo_ready = st_ff.tx_state == TX_IDLE;

	always_comb begin
		nxt_st = st_ff;
		// one bit time is two overflows
		tx_tick = tx_ovf && st_ff.tx_half;
		rx_sample = rx_ovf && !st_ff.rx_half;
		rx_ninth = 1'b0;
		rx_accept = 1'b0;
		if (tx_ovf) begin
			nxt_st.tx_half = !st_ff.tx_half;
		end
		if (rx_ovf) begin
			nxt_st.rx_half = !st_ff.rx_half;
		end
		nxt_st.rx_prev = serial_in_pin_in;
		// clears first so a same-cycle hardware set wins
		if (tx_done_clr_in) begin
			nxt_st.tx_done = 1'b0;
		end
		if (rx_done_clr_in) begin
			nxt_st.rx_done = 1'b0;
		end

		case (st_ff.tx_state)
			TX_IDLE: begin
				if (fifo_valid) begin
					nxt_st.tx_shift = {tx_extra_bit_in, fifo_data};
					nxt_st.tx_nine = frame_length_select_in != FRAME_SEL_8BIT;
					nxt_st.tx_bits = '0;
					nxt_st.tx_state = TX_WAIT;
				end
			end
			TX_WAIT: begin
				// wait for a bit boundary so the start bit is full length
				if (tx_tick) begin
					nxt_st.serial_out = 1'b0;
					nxt_st.tx_state = TX_START;
				end
			end
			TX_START: begin
				if (tx_tick) begin
					nxt_st.serial_out = st_ff.tx_shift[0];
					nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
					nxt_st.tx_bits = 4'h1;
					nxt_st.tx_state = TX_DATA;
				end
			end
			TX_DATA: begin
				if (tx_tick) begin
					if (st_ff.tx_bits == (st_ff.tx_nine ? FRAME_BITS_9 : FRAME_BITS_8)) begin
						nxt_st.serial_out = LINE_IDLE;
						nxt_st.tx_done = 1'b1;
						nxt_st.tx_state = TX_STOP;
					end else begin
						nxt_st.serial_out = st_ff.tx_shift[0];
						nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
						nxt_st.tx_bits = 4'(st_ff.tx_bits + 1'b1);
					end
				end
			end
			TX_STOP: begin
				if (tx_tick) begin
					nxt_st.tx_state = TX_IDLE;
				end
			end
			default: nxt_st.tx_state = TX_IDLE;
		endcase

		case (st_ff.rx_state)
			RX_IDLE: begin
				if (rx_force) begin
					nxt_st.rx_half = 1'b0;
					nxt_st.rx_bits = '0;
					nxt_st.rx_nine = frame_length_select_in != FRAME_SEL_8BIT;
					nxt_st.rx_state = RX_START;
				end
			end
			RX_START: begin
				// a glitch that is high again at mid-bit is no start
				if (rx_sample) begin
					nxt_st.rx_state = serial_in_pin_in ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				// shift register is apart from the buffer, so a held byte survives
				if (rx_sample) begin
					nxt_st.rx_shift[st_ff.rx_bits] = serial_in_pin_in;
					nxt_st.rx_bits = 4'(st_ff.rx_bits + 1'b1);
					if (4'(st_ff.rx_bits + 1'b1) == (st_ff.rx_nine ? FRAME_BITS_9 : FRAME_BITS_8)) begin
						nxt_st.rx_state = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_sample) begin
					// stop bit is the extra bit in short frames, ignored in long ones
					rx_ninth = st_ff.rx_nine ? st_ff.rx_shift[8] : serial_in_pin_in;
					rx_accept = !st_ff.rx_done && (!address_filter_enable_in || rx_ninth);
					if (rx_accept) begin
						nxt_st.rx_buf = st_ff.rx_shift[7:0];
						nxt_st.rx_extra = rx_ninth;
						nxt_st.rx_done = 1'b1;
					end
					// overrun: buffer untouched, new character simply dropped
					nxt_st.rx_state = RX_IDLE;
				end
			end
			default: nxt_st.rx_state = RX_IDLE;
		endcase

		nxt_st.irq = serial_irq_enable_in && (nxt_st.tx_done || nxt_st.rx_done);

		if (!resetn_in) begin
			nxt_st = '0;
			nxt_st.tx_state = TX_IDLE;
			nxt_st.rx_state = RX_IDLE;
			nxt_st.serial_out = LINE_IDLE;
			nxt_st.rx_prev = LINE_IDLE;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		st_ff <= nxt_st;
	end

	assign rx_data_out = st_ff.rx_buf;
	assign tx_done_flag_out = st_ff.tx_done;
	assign rx_done_flag_out = st_ff.rx_done;
	assign rx_extra_bit_out = st_ff.rx_extra;
	assign serial_irq_out = st_ff.irq;
	assign serial_out_pin_out = st_ff.serial_out;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	a_tx_done_stop: assert property (
		$rose(st_ff.tx_done) |-> st_ff.tx_state == TX_STOP && st_ff.serial_out)
		else $error("transmit done not raised at stop bit");
	a_rx_done_source: assert property (
		$rose(st_ff.rx_done) |-> $past(st_ff.rx_state) == RX_STOP && $past(rx_sample))
		else $error("receive done raised outside stop sample");
	a_overrun_hold: assert property (
		(st_ff.rx_done && !rx_done_clr_in) |=> $stable(st_ff.rx_buf) && st_ff.rx_done)
		else $error("held byte disturbed by overrun");
	a_filter_gate: assert property (
		($rose(st_ff.rx_done) && $past(address_filter_enable_in)) |-> st_ff.rx_extra)
		else $error("filtered character with extra bit zero accepted");
	a_irq_follow: assert property (
		(serial_irq_enable_in && st_ff.tx_done && !tx_done_clr_in) |=> st_ff.irq)
		else $error("interrupt missing with done flag set");
	a_flag_sticky: assert property (
		(st_ff.rx_done && !rx_done_clr_in) |=> st_ff.rx_done)
		else $error("receive done cleared without software");
	a_idle_line: assert property (
		st_ff.tx_state inside {TX_IDLE, TX_WAIT} |-> st_ff.serial_out)
		else $error("line not idle high between frames");
	a_start_bit: assert property (
		(st_ff.tx_state == TX_WAIT && tx_tick) |=> !st_ff.serial_out && st_ff.tx_state == TX_START)
		else $error("start bit not driven low");
	a_rx_gate: assert property (
		(st_ff.rx_state == RX_IDLE && !rx_enable_in) |=> st_ff.rx_state == RX_IDLE)
		else $error("receiver started while disabled");
	a_nine_extra: assert property (
		($rose(st_ff.rx_done) && st_ff.rx_nine) |-> st_ff.rx_extra == $past(st_ff.rx_shift[8]))
		else $error("ninth bit not stored as extra bit");

	a_rx_extra_short: assert property (
		($rose(st_ff.rx_done) && !st_ff.rx_nine) |-> st_ff.rx_extra == $past(serial_in_pin_in))
		else $error("stop bit not stored as extra bit");

	a_buf_load: assert property (
		$rose(st_ff.rx_done) |-> st_ff.rx_buf == $past(st_ff.rx_shift[7:0]))
		else $error("received byte not loaded into buffer");

	a_overrun_extra: assert property (
		(st_ff.rx_state == RX_STOP && rx_sample && st_ff.rx_done) |=>
			$stable(st_ff.rx_buf) && $stable(st_ff.rx_extra))
		else $error("overrunning character reached the buffer");

	a_pop_capture: assert property (
		(st_ff.tx_state == TX_IDLE && fifo_valid) |=>
			st_ff.tx_shift[7:0] == $past(fifo_data) && st_ff.tx_state == TX_WAIT)
		else $error("written byte not taken by the transmitter");

	a_ninth_capture: assert property (
		(st_ff.tx_state == TX_IDLE && fifo_valid) |=> st_ff.tx_shift[8] == $past(tx_extra_bit_in))
		else $error("ninth transmit bit not taken from software bit");

	a_tx_frame_select: assert property (
		(st_ff.tx_state == TX_IDLE && fifo_valid) |=> st_ff.tx_nine == $past(frame_length_select_in))
		else $error("transmit framing not taken from select");

	a_rx_frame_select: assert property (
		(st_ff.rx_state == RX_IDLE && rx_force) |=> st_ff.rx_nine == $past(frame_length_select_in))
		else $error("receive framing not taken from select");

	a_rx_align: assert property (
		(st_ff.rx_state == RX_IDLE && rx_force) |=> st_ff.rx_state == RX_START && !st_ff.rx_half)
		else $error("receiver not realigned on start");

	a_tx_bit_count: assert property (
		$rose(st_ff.tx_done) |-> $past(st_ff.tx_bits) == (st_ff.tx_nine ? FRAME_BITS_9 : FRAME_BITS_8))
		else $error("transmit frame length wrong");

	a_rx_bit_count: assert property (
		($changed(st_ff.rx_state) && st_ff.rx_state == RX_STOP) |->
			st_ff.rx_bits == (st_ff.rx_nine ? FRAME_BITS_9 : FRAME_BITS_8))
		else $error("receive frame length wrong");

	a_stop_high: assert property (
		st_ff.tx_state == TX_STOP |-> st_ff.serial_out)
		else $error("stop bit not driven high");

	a_tx_clear: assert property (
		(tx_done_clr_in && !(st_ff.tx_state == TX_DATA && tx_tick)) |=> !st_ff.tx_done)
		else $error("transmit done not cleared by software");

	a_rx_clear: assert property (
		(rx_done_clr_in && !(st_ff.rx_state == RX_STOP && rx_sample)) |=> !st_ff.rx_done)
		else $error("receive done not cleared by software");

	a_irq_quiet: assert property (
		!serial_irq_enable_in |=> !st_ff.irq)
		else $error("interrupt raised while disabled");

	c_rx_short: cover property ($rose(st_ff.rx_done) && !st_ff.rx_nine);
	c_rx_long: cover property ($rose(st_ff.rx_done) && st_ff.rx_nine);
	c_overrun: cover property (st_ff.rx_state == RX_STOP && rx_sample && st_ff.rx_done);
	c_tx_done: cover property ($rose(st_ff.tx_done) && st_ff.tx_nine);
	c_filter_drop: cover property (st_ff.rx_state == RX_STOP && rx_sample && !st_ff.rx_done && !rx_accept);
endmodule

/* File: design/uart_pkg.sv */
package uart_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int BAUD_W = 8;
	localparam int SEL_W = 3;
	localparam int CLK_PERIOD_NS = 100;
	// data bits per frame, ninth bit included in the long framing
	localparam logic [3:0] FRAME_BITS_8 = 4'h8;
	localparam logic [3:0] FRAME_BITS_9 = 4'h9;
	// frame length select: cleared is 8-bit framing
	localparam logic FRAME_SEL_8BIT = 1'b0;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic [BAUD_W-1:0] BAUD_CNT_MAX = 8'hff;
	localparam logic [BAUD_W-1:0] BAUD_CNT_RESET = 8'h00;
	// shared prescaler counts 0..47, serves the /4, /12 and /48 taps
	localparam logic [5:0] PRESCALE_LAST = 6'h2f;
	localparam logic [5:0] DIV12_MOD = 6'h0c;
	localparam logic [5:0] DIV12_LAST = 6'h0b;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [2:0] EXT_OSC_LAST = 3'h7;
	// baud timer clock source codes
	localparam logic [SEL_W-1:0] SRC_SYS = 3'h0;
	localparam logic [SEL_W-1:0] SRC_DIV4 = 3'h1;
	localparam logic [SEL_W-1:0] SRC_DIV12 = 3'h2;
	localparam logic [SEL_W-1:0] SRC_DIV48 = 3'h3;
	localparam logic [SEL_W-1:0] SRC_EXT_OSC8 = 3'h4;
	localparam logic [SEL_W-1:0] SRC_EXT_PIN = 3'h5;
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_STOP} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

/* File: tb/remote_serial_node.sv */
module remote_serial_node (
	input wire logic ref_clk_in,
	input wire logic serial_out_pin_in,
	output logic serial_in_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int bit_cycles = 8;
	logic nine_mode = 1'b0;
	logic [8:0] rx_q[$];
	logic [8:0] w;
	// line rests high between frames, like a real idle transmitter
	initial serial_in_pin_out = 1'b1;

	task automatic send_frame(input logic [7:0] d, input logic nine, input logic stop);
		logic [10:0] bits;
		int n;
		bits = nine_mode ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
		n = nine_mode ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk_in);
			serial_in_pin_out = bits[i];
			repeat (bit_cycles - 1) @(negedge ref_clk_in);
		end
		@(negedge ref_clk_in);
		serial_in_pin_out = 1'b1;
	endtask

	// samples mid-bit; bit 8 holds the stop bit (8-bit) or the ninth bit
	always begin
		@(negedge serial_out_pin_in);
		repeat (bit_cycles / 2) @(posedge ref_clk_in);
		if (serial_out_pin_in === 1'b0) begin
			for (int i = 0; i < 9; i++) begin
				repeat (bit_cycles) @(posedge ref_clk_in);
				w[i] = serial_out_pin_in;
			end
			// push at mid stop in both framings, so a done flag always leads it
			if (nine_mode) begin
				repeat (bit_cycles) @(posedge ref_clk_in);
			end
			rx_q.push_back(w);
		end
	end
endmodule

/* File: tb/tb_async_serial_port_with_baud_timer.sv */
module tb_async_serial_port_with_baud_timer;
	timeunit 1ns;
	timeprecision 1ns;
	import uart_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic tx_write = 1'b0;
	logic [DATA_W-1:0] tx_data = 8'h00;
	logic frame_sel = FRAME_SEL_8BIT;
	logic filt_en = 1'b0;
	logic rx_en = 1'b1;
	logic tx_x = 1'b0;
	logic irq_en = 1'b1;
	logic tx_clr = 1'b0;
	logic rx_clr = 1'b0;
	logic [SEL_W-1:0] baud_sel = SRC_SYS;
	logic [BAUD_W-1:0] reload = 8'hfc;
	logic ext_cnt = 1'b1;
	logic tx_ready, tx_done, rx_done, rx_x, irq, ser_in, ser_out;
	logic [DATA_W-1:0] rx_data;
	int num_errors = 0;
	int total_checks = 0;
	// bit time in clocks per source with reload 8'hfc: 2 * 4 ticks
	// oscillator ticks arrive every second clock, so its /8 gives a tick per 16 clocks
	int bit_tab[6] = '{8, 32, 96, 384, 128, 16};

	initial begin
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end
	// falling edge every second clock on the count pin
	always @(negedge clk) begin
		ext_cnt <= ~ext_cnt;
	end

	serial_port dut_u (
		.ref_clk_in(clk),
		.resetn_in(resetn),
		.tx_write_in(tx_write),
		.tx_write_data_in(tx_data),
		.tx_ready_out(tx_ready),
		.rx_data_out(rx_data),
		.frame_length_select_in(frame_sel),
		.address_filter_enable_in(filt_en),
		.rx_enable_in(rx_en),
		.tx_extra_bit_in(tx_x),
		.serial_irq_enable_in(irq_en),
		.tx_done_clr_in(tx_clr),
		.rx_done_clr_in(rx_clr),
		.tx_done_flag_out(tx_done),
		.rx_done_flag_out(rx_done),
		.rx_extra_bit_out(rx_x),
		.serial_irq_out(irq),
		.timer_enable_in(1'b1),
		.baud_reload_value_in(reload),
		.baud_clock_select_in(baud_sel),
		.ext_osc_tick_in(ext_cnt),
		.ext_count_input_in(ext_cnt),
		.serial_in_pin_in(ser_in),
		.serial_out_pin_out(ser_out)
	);

	remote_serial_node node_u (
		.ref_clk_in(clk),
		.serial_out_pin_in(ser_out),
		.serial_in_pin_out(ser_in)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic write_byte(input logic [7:0] d);
		@(negedge clk);
		tx_write = 1'b1;
		tx_data = d;
		@(negedge clk);
		tx_write = 1'b0;
	endtask

	task automatic clear_flags();
		@(negedge clk);
		tx_clr = 1'b1;
		rx_clr = 1'b1;
		@(negedge clk);
		tx_clr = 1'b0;
		rx_clr = 1'b0;
	endtask

	task automatic t_tx(input logic [7:0] d, input logic nine);
		logic [8:0] got;
		tx_x = nine;
		node_u.nine_mode = frame_sel;
		node_u.rx_q.delete();
		write_byte(d);
		for (int i = 0; i < 5000 && tx_done !== 1'b1; i++) cyc(1);
		check({tx_done, ser_out}, 2'b11);
		check(node_u.rx_q.size(), 0);
		cyc(1);
		check(irq, 1'b1);
		for (int i = 0; i < 5000 && node_u.rx_q.size() == 0; i++) cyc(1);
		got = node_u.rx_q.pop_front();
		check(got, {frame_sel ? nine : 1'b1, d});
		cyc(4);
		check(tx_done, 1'b1);
		clear_flags();
		cyc(1);
		check({tx_done, irq}, 2'b00);
	endtask

	task automatic t_fifo();
		int n;
		logic [8:0] got;
		n = 0;
		node_u.rx_q.delete();
		while (tx_ready === 1'b1 && n < 20) begin
			write_byte(8'(n));
			n++;
		end
		// sixteen held plus one already taken by the shifter
		check(n, 17);
		write_byte(8'hee);
		for (int i = 0; i < 4000 && node_u.rx_q.size() < 17; i++) cyc(1);
		cyc(200);
		check(node_u.rx_q.size(), 17);
		for (int i = 0; i < 17; i++) begin
			got = node_u.rx_q.pop_front();
			check(got, {1'b1, 8'(i)});
		end
		check(tx_ready, 1'b1);
		clear_flags();
	endtask

	task automatic rx_case(input logic [7:0] d, input logic nine, input logic stop,
			input logic done, input logic [7:0] exp_d, input logic exp_x);
		node_u.nine_mode = frame_sel;
		node_u.send_frame(d, nine, stop);
		cyc(2);
		check({rx_done, irq, rx_x, rx_data}, {done, done, exp_x, exp_d});
	endtask

	task automatic t_multidrop();
		filt_en = 1'b1;
		rx_case(8'hd0, 1'b0, 1'b1, 1'b0, 8'ha1, 1'b0);
		rx_case(8'h42, 1'b1, 1'b1, 1'b1, 8'h42, 1'b1);
		if (rx_data === 8'h42) begin
			filt_en = 1'b0;
		end
		clear_flags();
		rx_case(8'hd1, 1'b0, 1'b1, 1'b1, 8'hd1, 1'b0);
		clear_flags();
	endtask

	task automatic t_reload();
		// reload changed only while idle so no frame mixes two bit times
		reload = 8'hfa;
		node_u.bit_cycles = 12;
		cyc(20);
		t_tx(8'h69, 1'b0);
		reload = 8'hfc;
		node_u.bit_cycles = 8;
		cyc(20);
	endtask

	task automatic t_irq_mask();
		irq_en = 1'b0;
		node_u.nine_mode = frame_sel;
		node_u.send_frame(8'h24, 1'b0, 1'b1);
		cyc(2);
		check({rx_done, irq, rx_data}, {2'b10, 8'h24});
		irq_en = 1'b1;
		cyc(2);
		check(irq, 1'b1);
		clear_flags();
	endtask

	initial begin
		cyc(8);
		resetn = 1'b1;
		cyc(1);
		check({ser_out, tx_done, rx_done, irq, tx_ready, rx_data}, {5'b10001, 8'h00});
		t_tx(8'ha5, 1'b0);
		frame_sel = 1'b1;
		t_tx(8'h3c, 1'b1);
		t_tx(8'hc3, 1'b0);
		frame_sel = 1'b0;
		for (int s = 0; s < 6; s++) begin
			baud_sel = 3'(s);
			node_u.bit_cycles = bit_tab[s];
			t_tx(8'h96 ^ 8'(s), 1'b0);
		end
		baud_sel = SRC_SYS;
		node_u.bit_cycles = 8;
		t_reload();
		t_fifo();
		rx_case(8'h3c, 1'b0, 1'b1, 1'b1, 8'h3c, 1'b1);
		// clear lands while the next byte is still shifting in
		fork
			node_u.send_frame(8'h5b, 1'b0, 1'b1);
			clear_flags();
		join
		cyc(2);
		check({rx_done, rx_data}, 9'h15b);
		rx_case(8'hc3, 1'b0, 1'b1, 1'b1, 8'h5b, 1'b1);
		clear_flags();
		rx_case(8'h55, 1'b0, 1'b0, 1'b1, 8'h55, 1'b0);
		clear_flags();
		filt_en = 1'b1;
		rx_case(8'h77, 1'b0, 1'b0, 1'b0, 8'h55, 1'b0);
		filt_en = 1'b0;
		rx_en = 1'b0;
		rx_case(8'h11, 1'b0, 1'b1, 1'b0, 8'h55, 1'b0);
		rx_en = 1'b1;
		frame_sel = 1'b1;
		rx_case(8'ha1, 1'b0, 1'b0, 1'b1, 8'ha1, 1'b0);
		clear_flags();
		t_multidrop();
		t_irq_mask();
		test_done();
	end

	// whole run needs roughly 10000 clocks
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		test_done();
	end
endmodule
